// ==== src/adcc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // software control
   input wire logic sw_start,
   input wire logic [2:0] start_sel,
   input wire logic [4:0] pos_sel,
   input wire logic [4:0] neg_sel,
   input wire logic shutdown,
   input wire logic bg_mode,
   input wire logic done_int_en,
   input wire logic win_int_en,
   input wire logic win_inside,
   input wire logic [9:0] win_lo,
   input wire logic [9:0] win_hi,
   input wire logic done_clr,
   input wire logic win_clr,
   // trigger sources
   input wire logic [3:0] timer_ovf,
   input wire logic ext_start_pin,
   // converter core
   output logic conv_start,
   output logic core_en,
   output logic [4:0] mux_pos,
   output logic [4:0] mux_neg,
   input wire logic core_done,
   input wire logic [9:0] core_data,
   // status
   output logic [9:0] result,
   output logic done_flag,
   output logic win_flag,
   output logic busy,
   output logic irq
);

   adcc_pkg::adcc_state_t st_r;
   logic ext_s;
   logic ext_prev_r;
   logic ext_rise;
   logic trig_sel;
   logic launch;
   logic capture;
   logic win_hit;
   logic [9:0] gap_cnt_r;

   // start pin comes from outside, so it is synchronised first
   adcc_sync #(.W(1)) u_ext_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .d(ext_start_pin),
      .q(ext_s)
   );

   // edge detect on the synchronised copy only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev_r <= 1'b0;
      end else if (ce) begin
         ext_prev_r <= ext_s;
      end
   end

   assign ext_rise = ext_s & ~ext_prev_r;

   // pick the one trigger that software selected
   always_comb begin
      case (start_sel)
         adcc_pkg::SRC_SW: trig_sel = sw_start;
         adcc_pkg::SRC_T0: trig_sel = timer_ovf[0];
         adcc_pkg::SRC_T1: trig_sel = timer_ovf[1];
         adcc_pkg::SRC_T2: trig_sel = timer_ovf[2];
         adcc_pkg::SRC_T3: trig_sel = timer_ovf[3];
         adcc_pkg::SRC_EXT: trig_sel = ext_rise;
         default: trig_sel = 1'b0;
      endcase
   end

   // a trigger while busy, shut down or too soon is dropped, not queued
   assign launch = ce && (st_r == adcc_pkg::ST_IDLE) && !shutdown && trig_sel
                   && (gap_cnt_r == 10'h000);
   assign capture = ce && (st_r == adcc_pkg::ST_CONV) && core_done && !shutdown;

   // sequencer; shutdown aborts a conversion in flight
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= adcc_pkg::ST_IDLE;
      end else if (ce) begin
         case (st_r)
            adcc_pkg::ST_IDLE: begin
               if (launch) begin
                  st_r <= adcc_pkg::ST_CONV;
               end
            end
            adcc_pkg::ST_CONV: begin
               if (shutdown || core_done) begin
                  st_r <= adcc_pkg::ST_IDLE;
               end
            end
            default: st_r <= adcc_pkg::ST_IDLE;
         endcase
      end
   end

   // start-to-start spacing; faster rates are not needed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_cnt_r <= 10'h000;
      end else if (ce) begin
         if (launch) begin
            gap_cnt_r <= 10'(adcc_pkg::SAMPLE_CYC - 1);
         end else if (gap_cnt_r != 10'h000) begin
            gap_cnt_r <= gap_cnt_r - 10'h001;
         end
      end
   end

   // one-cycle start pulse and power enable to the core
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_start <= 1'b0;
         core_en <= 1'b0;
      end else if (ce) begin
         conv_start <= launch;
         core_en <= !shutdown;
      end
   end

   // selects follow software only while idle, so they hold during a conversion
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mux_pos <= adcc_pkg::MUX_RST;
         mux_neg <= adcc_pkg::MUX_RST;
      end else if (ce && st_r == adcc_pkg::ST_IDLE && !launch) begin
         mux_pos <= pos_sel;
         mux_neg <= neg_sel;
      end
   end

   // whole word latched in one edge, never half-updated
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result <= adcc_pkg::RESULT_RST;
      end else if (capture) begin
         result <= core_data;
      end
   end

   // window test on the fresh data
   always_comb begin
      if (win_inside) begin
         win_hit = (core_data >= win_lo) && (core_data <= win_hi);
      end else begin
         win_hit = (core_data < win_lo) || (core_data > win_hi);
      end
   end

   // sticky flags; a set in the clear cycle wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_flag <= 1'b0;
         win_flag <= 1'b0;
      end else if (ce) begin
         if (capture) begin
            done_flag <= 1'b1;
         end else if (done_clr) begin
            done_flag <= 1'b0;
         end
         if (capture && win_hit) begin
            win_flag <= 1'b1;
         end else if (win_clr) begin
            win_flag <= 1'b0;
         end
      end
   end

   // background mode silences completion, leaves the window path
   assign irq = (done_flag && done_int_en && !bg_mode)
                || (win_flag && win_int_en);
   assign busy = (st_r == adcc_pkg::ST_CONV);

   a_start_source: assert property (@(posedge clk) disable iff (!nrst)
      conv_start |-> $past(trig_sel) && $past(st_r) == adcc_pkg::ST_IDLE)
      else $error("start without selected trigger while idle");

   a_launch_pulse: assert property (@(posedge clk) disable iff (!nrst)
      launch |=> conv_start && busy)
      else $error("selected trigger did not start a conversion");

   a_done_capture: assert property (@(posedge clk) disable iff (!nrst)
      capture |=> done_flag && result == $past(core_data))
      else $error("result or completion flag not captured");

   a_done_irq: assert property (@(posedge clk) disable iff (!nrst)
      capture && done_int_en && !bg_mode ##1 done_int_en && !bg_mode |-> irq)
      else $error("completion interrupt missing");

   a_bg_quiet: assert property (@(posedge clk) disable iff (!nrst)
      bg_mode && !(win_flag && win_int_en) |-> !irq)
      else $error("background mode interrupted without window hit");

   a_win_inside: assert property (@(posedge clk) disable iff (!nrst)
      capture && win_inside && core_data >= win_lo && core_data <= win_hi
      |=> win_flag)
      else $error("inside-range hit not flagged");

   a_win_outside: assert property (@(posedge clk) disable iff (!nrst)
      capture && !win_inside && core_data >= win_lo && core_data <= win_hi
      && !win_flag && !win_clr |=> !win_flag)
      else $error("outside mode flagged an in-range result");

   a_mux_hold: assert property (@(posedge clk) disable iff (!nrst)
      busy && $past(busy) |-> $stable(mux_pos) && $stable(mux_neg))
      else $error("input selects changed during conversion");

   // sampled reset in the antecedent keeps the release edge, which still resets, out
   a_mux_follow: assert property (@(posedge clk) disable iff (!nrst)
      nrst && ce && !busy && !launch
      |=> mux_pos == $past(pos_sel) && mux_neg == $past(neg_sel))
      else $error("input selects did not follow software");

   a_shut_idle: assert property (@(posedge clk) disable iff (!nrst)
      ce && shutdown |=> !core_en && !conv_start && !busy)
      else $error("converter active while shut down");

   a_gap_min: assert property (@(posedge clk) disable iff (!nrst)
      conv_start |-> gap_cnt_r == 10'(adcc_pkg::SAMPLE_CYC - 1) ##1 !conv_start [*8])
      else $error("conversion starts spaced too closely");

   a_busy_ignore: assert property (@(posedge clk) disable iff (!nrst)
      busy |=> !conv_start)
      else $error("trigger accepted while busy");

endmodule
`default_nettype wire

// ==== include/adcc_pkg.sv ====
// Notes on behaviour
// - six start triggers: software, four timers, pin
// - completion sets flag, interrupts when enabled
// - full 10-bit result captured in one update
// - window compare interrupts inside or outside range
// - background mode interrupts only on window hit
// - positive and negative inputs chosen independently
// - temperature sensor and supply are selectable inputs
// - shutdown disables converter, no conversions run
// - starts spaced for at most 200 ksps
package adcc_pkg;

   // data and selector widths
   localparam int DATA_W = 10;
   localparam int MUX_W = 5;

   // start source encodings
   localparam logic [2:0] SRC_SW = 3'h0;
   localparam logic [2:0] SRC_T0 = 3'h1;
   localparam logic [2:0] SRC_T1 = 3'h2;
   localparam logic [2:0] SRC_T2 = 3'h3;
   localparam logic [2:0] SRC_T3 = 3'h4;
   localparam logic [2:0] SRC_EXT = 3'h5;

   // special multiplexer codes; lower codes are port pins
   localparam logic [4:0] MUX_TEMP = 5'h1E;
   localparam logic [4:0] MUX_VDD = 5'h1F;
   localparam logic [4:0] NEG_GND = 5'h1F;

   // reset values
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [4:0] MUX_RST = 5'h1F;

   // sample period at the top rate, rounded up to whole cycles
   localparam int CLK_NS = 10;
   localparam int SAMPLE_NS = 5000;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

   // sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_CONV
   } adcc_state_t;

endpackage

// ==== src/adcc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_sync #(
   parameter int W = 1
) (
   // clock, reset and enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // asynchronous input and its synchronised copy
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // two flops; first is read only by the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule
`default_nettype wire

// ==== sim/adcc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model #(
   parameter int LAT = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control from the block
   input wire logic conv_start,
   input wire logic core_en,
   input wire logic [9:0] level,
   // answer to the block
   output logic core_done,
   output logic [9:0] core_data
);
   int cnt;
   // fixed conversion time; data churns outside the valid pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         core_done <= 1'b0;
         core_data <= 10'h3ff;
      end else begin
         core_done <= 1'b0;
         core_data <= ~core_data;
         if (!core_en) begin
            cnt <= 0;
         end else if (conv_start) begin
            cnt <= LAT;
         end else if (cnt == 1) begin
            core_done <= 1'b1;
            core_data <= level;
            cnt <= 0;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int LAT = 20;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sw_start = 1'b0, shutdown = 1'b0, bg_mode = 1'b0, done_int_en = 1'b1;
   logic win_int_en = 1'b0, win_inside = 1'b0, done_clr = 1'b0, win_clr = 1'b0;
   logic ext_start_pin = 1'b0;
   logic [2:0] start_sel = 3'h0;
   logic [3:0] timer_ovf = 4'h0;
   logic [4:0] pos_sel = 5'h00, neg_sel = 5'h00, mux_pos, mux_neg;
   logic [9:0] win_lo = 10'h000, win_hi = 10'h000, level = 10'h000, core_data, result;
   logic conv_start, core_en, core_done, done_flag, win_flag, busy, irq;
   int error_cnt = 0, cmp_count = 0, cyc = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   adcc_ctrl uut (.clk(clk), .nrst(nrst), .ce(1'b1), .sw_start(sw_start),
      .start_sel(start_sel), .pos_sel(pos_sel), .neg_sel(neg_sel), .shutdown(shutdown),
      .bg_mode(bg_mode), .done_int_en(done_int_en), .win_int_en(win_int_en),
      .win_inside(win_inside), .win_lo(win_lo), .win_hi(win_hi), .done_clr(done_clr),
      .win_clr(win_clr), .timer_ovf(timer_ovf), .ext_start_pin(ext_start_pin),
      .conv_start(conv_start), .core_en(core_en), .mux_pos(mux_pos), .mux_neg(mux_neg),
      .core_done(core_done), .core_data(core_data), .result(result),
      .done_flag(done_flag), .win_flag(win_flag), .busy(busy), .irq(irq));

   adcc_core_model #(.LAT(LAT)) core (.clk(clk), .nrst(nrst), .conv_start(conv_start),
      .core_en(core_en), .level(level), .core_done(core_done), .core_data(core_data));

   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         final_report();
      end
   end

   // one-cycle trigger pulse; the pin stays high until run() drops it
   task automatic fire(input logic [2:0] src);
      @(posedge clk);
      case (src)
         3'h0: sw_start <= 1'b1;
         3'h5: ext_start_pin <= 1'b1;
         default: timer_ovf <= 4'h1 << (src - 3'h1);
      endcase
      @(posedge clk);
      sw_start <= 1'b0;
      timer_ovf <= 4'h0;
   endtask

   // pin start needs sync plus edge detect, so allow 8 cycles
   task automatic run(input logic e, input logic [9:0] v);
      int i;
      for (i = 0; i < 8 && busy !== 1'b1; i++) @(posedge clk) #1;
      chk("busy", {9'h000, e}, {9'h000, busy});
      for (i = 0; i < LAT + 20 && busy === 1'b1; i++) @(posedge clk) #1;
      ext_start_pin <= 1'b0;
      if (e) begin
         chk("result", v, result);
         chk("done_flag", 10'h001, {9'h000, done_flag});
      end
   endtask

   // waits out the sample gap first so a start is legal
   task automatic conv(input logic [2:0] src, input logic [9:0] v, input logic e);
      repeat (adcc_pkg::SAMPLE_CYC) @(posedge clk);
      level <= v;
      fire(src);
      run(e, v);
   endtask

   task automatic clr;
      @(posedge clk);
      done_clr <= 1'b1;
      win_clr <= 1'b1;
      @(posedge clk);
      done_clr <= 1'b0;
      win_clr <= 1'b0;
      @(posedge clk) #1;
   endtask

   task automatic t_sources;
      int s;
      for (s = 0; s < 6; s++) begin
         start_sel <= s[2:0];
         conv(s[2:0], 10'h100 + 10'(s), 1'b1);
         chk("irq", 10'h001, {9'h000, irq});
         clr();
         chk("irq", 10'h000, {9'h000, irq});
      end
      $display("test sources done");
   endtask

   task automatic t_select;
      start_sel <= adcc_pkg::SRC_T0;
      conv(adcc_pkg::SRC_T1, 10'h055, 1'b0);
      fire(adcc_pkg::SRC_SW);
      run(1'b0, 10'h055);
      fire(adcc_pkg::SRC_T0);
      run(1'b1, 10'h055);
      done_int_en <= 1'b0;
      @(posedge clk) #1 chk("irq", 10'h000, {9'h000, irq});
      done_int_en <= 1'b1;
      fire(adcc_pkg::SRC_T0);
      run(1'b0, 10'h055);
      clr();
      $display("test select done");
   endtask

   // {hit, inside, value}: bounds inclusive inside, strict outside
   task automatic t_window;
      logic [11:0] tbl [6] = '{12'hD00, 12'hE00, 12'h601, 12'h8FF, 12'h100, 12'hBFF};
      bg_mode <= 1'b1;
      win_int_en <= 1'b1;
      win_lo <= 10'h100;
      win_hi <= 10'h200;
      start_sel <= adcc_pkg::SRC_SW;
      foreach (tbl[i]) begin
         win_inside <= tbl[i][10];
         conv(adcc_pkg::SRC_SW, tbl[i][9:0], 1'b1);
         chk("win_flag", {9'h000, tbl[i][11]}, {9'h000, win_flag});
         chk("irq", {9'h000, tbl[i][11]}, {9'h000, irq});
         clr();
      end
      bg_mode <= 1'b0;
      win_int_en <= 1'b0;
      $display("test window done");
   endtask

   task automatic t_shut;
      shutdown <= 1'b1;
      conv(adcc_pkg::SRC_SW, 10'h2aa, 1'b0);
      chk("core_en", 10'h000, {9'h000, core_en});
      shutdown <= 1'b0;
      repeat (adcc_pkg::SAMPLE_CYC) @(posedge clk);
      fire(adcc_pkg::SRC_SW);
      repeat (3) @(posedge clk);
      shutdown <= 1'b1;
      repeat (LAT + 5) @(posedge clk);
      #1 chk("done_flag", 10'h000, {9'h000, done_flag});
      shutdown <= 1'b0;
      $display("test shutdown done");
   endtask

   task automatic t_mux;
      pos_sel <= adcc_pkg::MUX_TEMP;
      neg_sel <= 5'h03;
      repeat (2) @(posedge clk);
      #1 chk("mux_pos", {5'h00, adcc_pkg::MUX_TEMP}, {5'h00, mux_pos});
      chk("mux_neg", 10'h003, {5'h00, mux_neg});
      pos_sel <= adcc_pkg::MUX_VDD;
      neg_sel <= adcc_pkg::NEG_GND;
      repeat (2) @(posedge clk);
      #1 chk("mux_pos", {5'h00, adcc_pkg::MUX_VDD}, {5'h00, mux_pos});
      chk("mux_neg", {5'h00, adcc_pkg::NEG_GND}, {5'h00, mux_neg});
      $display("test mux done");
   endtask

   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      #1 chk("result", 10'h000, result);
      chk("mux_pos", {5'h00, adcc_pkg::MUX_RST}, {5'h00, mux_pos});
      t_mux();
      t_sources();
      t_select();
      t_window();
      t_shut();
      final_report();
   end
endmodule
`default_nettype wire
